//--- rtl/spi_err_pkg.sv
package spi_err_pkg;

	// ----------------------------------------------------------------
	// Sizes
	// ----------------------------------------------------------------
	localparam int unsigned SPI_COUNT_MAX = 960;
	localparam int unsigned WORD_W        = 32;
	localparam int unsigned REG_FIRST     = 1;
	localparam int unsigned REG_LAST      = 30;
	localparam int unsigned ADDR_W        = 12;
	localparam int unsigned IDX_LSB       = 2;
	localparam int unsigned IDX_W         = 5;
	localparam int unsigned VIEW_W        = 2;

	// ----------------------------------------------------------------
	// Address map
	// ----------------------------------------------------------------
	localparam logic [11:0] OFF_CLR_BANK  = 12'h000;
	localparam logic [11:0] OFF_GCLR_BANK = 12'h080;
	localparam logic [11:0] OFF_SET_BANK  = 12'h100;
	localparam logic [11:0] OFF_CTRL      = 12'h180;
	localparam logic [11:0] OFF_IRQ_STAT  = 12'h184;
	localparam logic [11:0] OFF_IRQ_MASK  = 12'h188;
	localparam logic [11:0] BANK_MASK     = 12'hf80;

	// ----------------------------------------------------------------
	// Fields and reset values
	// ----------------------------------------------------------------
	localparam int unsigned CTRL_MVIEW_BIT  = 0;
	localparam logic        CTRL_MVIEW_RST  = 1'h0;
	localparam int unsigned PROT_NS_BIT     = 1;
	localparam logic [1:0]  VIEW_ZERO       = 2'h0;
	localparam int unsigned IRQ_W           = 3;
	localparam int unsigned IRQ_HW_FAULT    = 0;
	localparam int unsigned IRQ_SEC_REFUSED = 1;
	localparam int unsigned IRQ_NS_BLOCKED  = 2;
	localparam logic [2:0]  IRQ_RST         = 3'h0;
	localparam logic [31:0] ERR_RST         = 32'h0;

	// ----------------------------------------------------------------
	// Types
	// ----------------------------------------------------------------
	typedef struct packed {
		logic [31:0] clr;
		logic [31:0] gclr;
		logic [31:0] set;
		logic [31:0] view;
	} word_ctl_s;

	typedef enum {st_idle, st_resp} apb_st_e;

	typedef enum {bank_none, bank_clr, bank_gclr, bank_set,
		bank_ctrl, bank_istat, bank_imask} bank_e;

endpackage

//--- rtl/spi_err_word.sv
`timescale 1ns/100ps
module spi_err_word
	import spi_err_pkg::*;
(
	input  wire logic        pclk,
	input  wire logic        presetn,
	input  wire word_ctl_s   ctl,
	input  wire logic [31:0] fault,
	output logic      [31:0] err_q,
	output logic      [31:0] grp_q,
	output logic      [31:0] view_q
);

	logic [31:0] err_d;
	logic [31:0] grp_d;
	logic [31:0] view_d;

	// ----------------------------------------------------------------
	// Error state of 32 SPIs, sets win over clears
	// ----------------------------------------------------------------
	always_comb
	begin
		err_d  = (err_q & ~ctl.clr) | ctl.set | fault;
		grp_d  = (grp_q & ~ctl.gclr) | ctl.set | fault;
		view_d = (view_q & ~ctl.clr) | ctl.view;
	end

	always_ff @(posedge pclk or negedge presetn)
	begin
		if (!presetn)
		begin
			err_q  <= ERR_RST;
			grp_q  <= ERR_RST;
			view_q <= ERR_RST;
		end
		else
		begin
			err_q  <= err_d;
			grp_q  <= grp_d;
			view_q <= view_d;
		end
	end

endmodule

//--- rtl/spi_err_irq.sv
`timescale 1ns/100ps
module spi_err_irq
	import spi_err_pkg::*;
#(
	parameter int unsigned W = IRQ_W
)
(
	input  wire logic         pclk,
	input  wire logic         presetn,
	input  wire logic [W-1:0] evt,
	input  wire logic         wr_status,
	input  wire logic         wr_mask,
	input  wire logic [W-1:0] wdata,
	output logic      [W-1:0] status_q,
	output logic      [W-1:0] mask_q,
	output logic              irq_q
);

	logic [W-1:0] status_d;
	logic [W-1:0] mask_d;
	logic         irq_d;

	// ----------------------------------------------------------------
	// Sticky status, write one to clear, event wins
	// ----------------------------------------------------------------
	always_comb
	begin
		status_d = (status_q & ~(wr_status ? wdata : '0)) | evt;
		mask_d   = wr_mask ? wdata : mask_q;
		irq_d    = |(status_d & mask_d);
	end

	always_ff @(posedge pclk or negedge presetn)
	begin
		if (!presetn)
		begin
			status_q <= W'(IRQ_RST);
			mask_q   <= W'(IRQ_RST);
			irq_q    <= 1'b0;
		end
		else
		begin
			status_q <= status_d;
			mask_q   <= mask_d;
			irq_q    <= irq_d;
		end
	end

endmodule

//--- rtl/spi_error_status_registers.sv
// The implementer's own choices: the register offsets and the APB interface to the registers.
`timescale 1ns/100ps
//
// Function
// - Thirty clear-error words, 32 SPIs each, one status bit per SPI.
// - Fewer SPIs: fewer words; unimplemented words read zero, ignore writes.
// - Any bank read: bit is one when that SPI is in error.
// - Writing zero leaves the SPI error state unchanged in every bank.
// - Writing one to a clear-error bit removes that SPI's error.
// - Non-secure clear only after secure software cleared the group error.
// - Bit b of word n maps to SPI 32 times (n minus 1) plus b.
// - Writing one to group-clear bit clears that SPI's group error.
// - Writing one to set-error bit forces error and contains the SPI.
// - Multi-view: view 0 also sets view error; others group and error.
// - Group-clear and set-error banks accept secure accesses only.
module spi_error_status_registers
	import spi_err_pkg::*;
#(
	parameter int unsigned NUM_SPI = SPI_COUNT_MAX
)
(
	input  wire logic               pclk,
	input  wire logic               presetn,
	input  wire logic               psel,
	input  wire logic               penable,
	input  wire logic               pwrite,
	input  wire logic [11:0]        paddr,
	input  wire logic [31:0]        pwdata,
	input  wire logic [2:0]         pprot,
	input  wire logic [1:0]         access_view,
	input  wire logic [NUM_SPI-1:0] spi_fault,
	output logic      [31:0]        prdata,
	output logic                    pready,
	output logic                    pslverr,
	output logic                    irq,
	output logic      [NUM_SPI-1:0] spi_error,
	output logic      [NUM_SPI-1:0] spi_group_error,
	output logic      [NUM_SPI-1:0] spi_view_error
);

	localparam int unsigned REG_COUNT = NUM_SPI / WORD_W;
	localparam logic [4:0]  REG_CNT5  = 5'(REG_COUNT);

	apb_st_e      st_q;
	apb_st_e      st_d;
	bank_e        bank;
	logic [4:0]   idx;
	logic         impl;
	logic         secure;
	logic         first_acc;
	logic         commit;
	logic         refused;
	logic         ns_blocked;
	logic         pready_d;
	logic         pslverr_d;
	logic [31:0]  prdata_d;
	logic         mview_q;
	logic         mview_d;
	logic         set_view;
	logic [2:0]   evt;
	logic [2:0]   istat;
	logic [2:0]   imask;
	logic [31:0]  err_w  [0:31];
	logic [31:0]  grp_w  [0:31];
	logic [31:0]  view_w [0:31];

	// ----------------------------------------------------------------
	// Address decode
	// ----------------------------------------------------------------
	always_comb
	begin
		idx  = paddr[IDX_LSB +: IDX_W];
		bank = bank_none;
		if (paddr[1:0] == 2'h0)
		begin
			case (paddr & BANK_MASK)
				OFF_CLR_BANK:  bank = bank_clr;
				OFF_GCLR_BANK: bank = bank_gclr;
				OFF_SET_BANK:  bank = bank_set;
				default:
				begin
					case (paddr)
						OFF_CTRL:     bank = bank_ctrl;
						OFF_IRQ_STAT: bank = bank_istat;
						OFF_IRQ_MASK: bank = bank_imask;
						default:      bank = bank_none;
					endcase
				end
			endcase
		end
		impl      = (idx >= 5'h01) && (idx <= REG_CNT5);
		secure    = !pprot[PROT_NS_BIT];
		first_acc = psel && penable && !pready;
		commit    = psel && penable && pready && pwrite;
		refused   = ((bank == bank_gclr) || (bank == bank_set))
			&& !secure;
		set_view  = mview_q && (access_view == VIEW_ZERO);
	end

	// ----------------------------------------------------------------
	// Error words, one per register index
	// ----------------------------------------------------------------
	genvar n;
	generate
		for (n = 0; n < 32; n = n + 1)
		begin : g_word
			if (n >= REG_FIRST && n <= REG_LAST && n <= REG_COUNT)
			begin : g_impl
				word_ctl_s ctl;
				logic      hit;
				assign hit = commit && (idx == 5'(n));
				assign ctl.clr  = (hit && bank == bank_clr) ?
					(pwdata & (secure ? 32'hffffffff : ~grp_w[n])) : 32'h0;
				assign ctl.gclr = (hit && bank == bank_gclr && secure) ?
					pwdata : 32'h0;
				assign ctl.set  = (hit && bank == bank_set && secure) ?
					pwdata : 32'h0;
				assign ctl.view = set_view ? ctl.set : 32'h0;
				spi_err_word u_word (
					.pclk    (pclk),
					.presetn (presetn),
					.ctl     (ctl),
					.fault   (spi_fault[(n-1)*WORD_W +: WORD_W]),
					.err_q   (err_w[n]),
					.grp_q   (grp_w[n]),
					.view_q  (view_w[n])
				);
				assign spi_error[(n-1)*WORD_W +: WORD_W]       = err_w[n];
				assign spi_group_error[(n-1)*WORD_W +: WORD_W] = grp_w[n];
				assign spi_view_error[(n-1)*WORD_W +: WORD_W]  = view_w[n];
			end
			else
			begin : g_raz
				assign err_w[n]  = 32'h0;
				assign grp_w[n]  = 32'h0;
				assign view_w[n] = 32'h0;
			end
		end
	endgenerate

	// ----------------------------------------------------------------
	// Interrupt status
	// ----------------------------------------------------------------
	always_comb
	begin
		ns_blocked = commit && (bank == bank_clr) && !secure && impl
			&& |(pwdata & grp_w[idx]);
		evt = 3'h0;
		evt[IRQ_HW_FAULT]    = |spi_fault;
		evt[IRQ_SEC_REFUSED] = first_acc && refused;
		evt[IRQ_NS_BLOCKED]  = ns_blocked;
	end

	spi_err_irq #(.W(IRQ_W)) u_irq (
		.pclk      (pclk),
		.presetn   (presetn),
		.evt       (evt),
		.wr_status (commit && bank == bank_istat),
		.wr_mask   (commit && bank == bank_imask),
		.wdata     (pwdata[IRQ_W-1:0]),
		.status_q  (istat),
		.mask_q    (imask),
		.irq_q     (irq)
	);

	// ----------------------------------------------------------------
	// APB response, one wait state
	// ----------------------------------------------------------------
	always_comb
	begin
		st_d = st_idle;
		case (st_q)
			st_idle:  st_d = first_acc ? st_resp : st_idle;
			st_resp:  st_d = st_idle;
			default:  st_d = st_idle;
		endcase
		pready_d  = (st_d == st_resp);
		pslverr_d = first_acc && ((bank == bank_none) || refused);
		mview_d   = (commit && bank == bank_ctrl) ?
			pwdata[CTRL_MVIEW_BIT] : mview_q;
		prdata_d  = 32'h0;
		if (first_acc && !pwrite && !pslverr_d)
		begin
			case (bank)
				bank_clr, bank_gclr, bank_set:
					prdata_d = err_w[idx];
				bank_ctrl:  prdata_d = {31'h0, mview_q};
				bank_istat: prdata_d = {29'h0, istat};
				bank_imask: prdata_d = {29'h0, imask};
				default:    prdata_d = 32'h0;
			endcase
		end
	end

	always_ff @(posedge pclk or negedge presetn)
	begin
		if (!presetn)
		begin
			st_q    <= st_idle;
			pready  <= 1'b0;
			pslverr <= 1'b0;
			prdata  <= 32'h0;
			mview_q <= CTRL_MVIEW_RST;
		end
		else
		begin
			st_q    <= st_d;
			pready  <= pready_d;
			pslverr <= pslverr_d;
			prdata  <= prdata_d;
			mview_q <= mview_d;
		end
	end

	// ----------------------------------------------------------------
	// Assertions
	// ----------------------------------------------------------------
	default clocking cb @(posedge pclk); endclocking
	default disable iff (!presetn);

	logic wr_w1b0;
	assign wr_w1b0 = commit && idx == 5'h01 && pwdata[0] && !spi_fault[0];

	a_ready_one_wait: assert property (psel && penable && !pready
		|=> pready ##1 !pready)
		else $error("pready not one cycle after wait");
	a_pready_pulse: assert property (pready |=> !pready)
		else $error("pready held longer than one cycle");
	a_idle_quiet: assert property (!psel |=> !pready)
		else $error("pready without a selected transfer");
	a_slverr_ready: assert property (pslverr |-> pready)
		else $error("pslverr raised without pready");
	a_secure_refuse: assert property (first_acc && refused
		|=> pslverr && prdata == 32'h0)
		else $error("non-secure access to secure bank accepted");
	a_refuse_flag: assert property (first_acc && refused
		|=> istat[IRQ_SEC_REFUSED])
		else $error("refused access not flagged");
	a_gclr_secure: assert property (commit && bank == bank_gclr
		&& !secure && !(|spi_fault) |=> grp_w[1] == $past(grp_w[1]))
		else $error("non-secure group clear took effect");
	a_set_secure: assert property (commit && bank == bank_set
		&& !secure && !(|spi_fault) |=> err_w[2] == $past(err_w[2]))
		else $error("non-secure set took effect");
	a_set_forces: assert property (commit && bank == bank_set
		&& secure && idx == 5'h01 && pwdata[0]
		|=> err_w[1][0] && grp_w[1][0])
		else $error("set write did not force error");
	a_fault_sets: assert property (spi_fault[0]
		|=> err_w[1][0] && grp_w[1][0] && istat[IRQ_HW_FAULT])
		else $error("hardware fault did not set error");
	a_clear_works: assert property (wr_w1b0 && bank == bank_clr
		&& secure |=> !err_w[1][0])
		else $error("clear write did not clear error");
	a_zero_keeps: assert property (commit && idx == 5'h01
		&& !pwdata[0] && !spi_fault[0]
		|=> err_w[1][0] == $past(err_w[1][0]))
		else $error("zero write changed error state");
	a_ns_blocked: assert property (wr_w1b0 && bank == bank_clr
		&& !secure && grp_w[1][0] && err_w[1][0] |=> err_w[1][0])
		else $error("non-secure clear with group error pending");
	a_ns_allowed: assert property (wr_w1b0 && bank == bank_clr
		&& !secure && !grp_w[1][0] |=> !err_w[1][0])
		else $error("non-secure clear after group clear ignored");
	a_block_flag: assert property (ns_blocked
		|=> istat[IRQ_NS_BLOCKED])
		else $error("blocked clear not flagged");
	a_gclr_works: assert property (wr_w1b0 && bank == bank_gclr
		&& secure |=> !grp_w[1][0])
		else $error("group clear write did not clear");
	a_gclr_keeps: assert property (wr_w1b0 && bank == bank_gclr
		&& secure && err_w[1][0] |=> err_w[1][0])
		else $error("group clear removed error state");
	a_view_set: assert property (commit && bank == bank_set
		&& secure && idx == 5'h01 && pwdata[0] && set_view
		|=> view_w[1][0])
		else $error("view zero set did not set view error");
	a_view_only: assert property (commit && bank == bank_set
		&& !set_view && idx == 5'h01 && !view_w[1][0]
		|=> !view_w[1][0])
		else $error("view error set outside view zero");
	a_unimpl_raz: assert property (first_acc && !pwrite && !impl
		&& (bank == bank_clr || bank == bank_set) |=> prdata == 32'h0)
		else $error("unimplemented word read not zero");
	a_read_steady: assert property (psel && !pwrite
		&& !(|spi_fault) |=> err_w[1] == $past(err_w[1]))
		else $error("read changed error state");
	a_bit_map: assert property (commit && bank == bank_set && secure
		&& idx == 5'h02 && pwdata[5] |=> spi_error[37])
		else $error("bit mapping to SPI number wrong");
	a_read_status: assert property (first_acc && !pwrite
		&& bank == bank_clr && idx == 5'h01 && !(|spi_fault[31:0])
		|=> prdata == err_w[1])
		else $error("read data not error state");

	// ----------------------------------------------------------------
	// Covers
	// ----------------------------------------------------------------
	c_set_then_clear: cover property (commit && bank == bank_set
		##[1:20] commit && bank == bank_clr);
	c_ns_refused: cover property (first_acc && refused);
	c_irq_raised: cover property (!irq ##1 irq);
	c_view_set: cover property (commit && bank == bank_set && set_view);
	c_fault_seen: cover property (|spi_fault ##1 irq);

endmodule

//--- tb/tb_spi_error_status_registers.sv
`timescale 1ns/100ps
module tb_spi_error_status_registers;
	import spi_err_pkg::*;

	// ------------------------------------------------------------
	// Signals and model state
	// ------------------------------------------------------------
	logic         pclk;
	logic         presetn;
	logic         psel;
	logic         penable;
	logic         pwrite;
	logic [11:0]  paddr;
	logic [31:0]  pwdata;
	logic [2:0]   pprot;
	logic [1:0]   access_view;
	logic [127:0] spi_fault;
	logic [31:0]  prdata;
	logic         pready;
	logic         pslverr;
	logic         irq;
	logic [127:0] spi_error;
	logic [127:0] spi_group_error;
	logic [127:0] spi_view_error;
	logic [127:0] e_m;
	logic [127:0] g_m;
	logic [127:0] v_m;
	logic [31:0]  rd;
	logic         er;
	logic         mv;
	int           miscompares;
	int           check_count;

	spi_error_status_registers #(.NUM_SPI(128)) uut
	(
		.pclk            (pclk),
		.presetn         (presetn),
		.psel            (psel),
		.penable         (penable),
		.pwrite          (pwrite),
		.paddr           (paddr),
		.pwdata          (pwdata),
		.pprot           (pprot),
		.access_view     (access_view),
		.spi_fault       (spi_fault),
		.prdata          (prdata),
		.pready          (pready),
		.pslverr         (pslverr),
		.irq             (irq),
		.spi_error       (spi_error),
		.spi_group_error (spi_group_error),
		.spi_view_error  (spi_view_error)
	);

	initial
	begin
		pclk = 1'b0;
		forever #2 pclk = ~pclk;
	end

	// ------------------------------------------------------------
	// Tasks
	// ------------------------------------------------------------
	task automatic wrap_up();
		$display("Checks %0d, miscompares %0d", check_count, miscompares);
		if (miscompares == 0 && check_count > 0)
			$display("TEST PASSED");
		else
			$display("TEST FAILED");
		$finish;
	endtask

	task automatic chk(input string nm, input logic [31:0] s,
		input logic [31:0] x);
		check_count++;
		if (s !== x)
		begin
			miscompares++;
			$display("Error %s expected %h seen %h", nm, x, s);
		end
	endtask

	function automatic logic [31:0] ew(input logic [127:0] v, input int n);
		if (n < 1 || n > 4)
			return 32'h0;
		return v[32*(n-1)+:32];
	endfunction

	task automatic apb(input logic w, input logic [11:0] a,
		input logic [31:0] d, input logic ns);
		int k;
		@(posedge pclk);
		psel    <= 1'b1;
		pwrite  <= w;
		paddr   <= a;
		pwdata  <= d;
		pprot   <= {1'b0, ns, 1'b0};
		@(posedge pclk);
		penable <= 1'b1;
		k = 0;
		do
		begin
			@(posedge pclk);
			k++;
		end
		while (pready !== 1'b1 && k < 20);
		if (k >= 20)
		begin
			miscompares++;
			wrap_up();
		end
		else
		begin
			rd = prdata;
			er = pslverr;
			psel    <= 1'b0;
			penable <= 1'b0;
		end
	endtask

	task automatic wr(input int b, input int n, input logic [31:0] d,
		input logic ns);
		logic [127:0] m;
		m = (n >= 1 && n <= 4) ? {96'h0, d} << (32 * (n - 1)) : '0;
		apb(1'b1, 12'(128 * b + 4 * n), d, ns);
		chk("wr_err", {31'h0, er}, {31'h0, ns && b != 0});
		if (ns && b != 0)
			m = '0;
		if (b == 0)
		begin
			if (ns)
				m = m & ~g_m;
			e_m &= ~m;
			v_m &= ~m;
		end
		else if (b == 1)
			g_m &= ~m;
		else
		begin
			e_m |= m;
			g_m |= m;
			if (mv && access_view == 2'h0)
				v_m |= m;
		end
	endtask

	task automatic rdall(input string nm);
		for (int n = 0; n < 32; n++)
			for (int b = 0; b < 3; b++)
			begin
				apb(1'b0, 12'(128 * b + 4 * n), 32'h0, 1'b0);
				chk("bank_word", rd, ew(e_m, n));
				chk("rd_err", {31'h0, er}, 32'h0);
			end
		for (int n = 1; n <= 4; n++)
		begin
			chk("spi_error", spi_error[32*(n-1)+:32], ew(e_m, n));
			chk("spi_group", spi_group_error[32*(n-1)+:32], ew(g_m, n));
			chk("spi_view", spi_view_error[32*(n-1)+:32], ew(v_m, n));
		end
		$display("Test %s done", nm);
	endtask

	// ------------------------------------------------------------
	// Main sequence
	// ------------------------------------------------------------
	initial
	begin
		presetn = 1'b0;
		psel = 1'b0;
		penable = 1'b0;
		pwrite = 1'b0;
		paddr = 12'h0;
		pwdata = 32'h0;
		pprot = 3'h0;
		access_view = 2'h1;
		spi_fault = '0;
		e_m = '0;
		g_m = '0;
		v_m = '0;
		mv = 1'b0;
		miscompares = 0;
		check_count = 0;
		void'($urandom(64186));
		repeat (16) @(posedge pclk);
		presetn <= 1'b1;
		rdall("reset");
		chk("irq", {31'h0, irq}, 32'h0);
		wr(2, 1, 32'h8000_0001, 1'b0);
		wr(0, 1, 32'h0, 1'b0);
		wr(0, 1, 32'h0000_0001, 1'b1);
		rdall("blocked clear");
		wr(1, 1, 32'h8000_0000, 1'b1);
		wr(1, 1, 32'h0000_0001, 1'b0);
		wr(0, 1, 32'h0000_0001, 1'b1);
		wr(2, 5, 32'hffff_ffff, 1'b0);
		wr(2, 0, 32'hffff_ffff, 1'b0);
		wr(2, 31, 32'hffff_ffff, 1'b0);
		rdall("clear after group");
		apb(1'b1, OFF_IRQ_MASK, 32'h7, 1'b0);
		wr(2, 2, 32'hffff_ffff, 1'b1);
		repeat (3) @(posedge pclk);
		chk("irq", {31'h0, irq}, 32'h1);
		apb(1'b0, OFF_IRQ_STAT, 32'h0, 1'b0);
		chk("irq_status", rd, 32'h6);
		apb(1'b1, OFF_IRQ_STAT, 32'h6, 1'b0);
		repeat (3) @(posedge pclk);
		chk("irq", {31'h0, irq}, 32'h0);
		apb(1'b0, 12'h1fc, 32'h0, 1'b0);
		chk("unmapped_err", {31'h0, er}, 32'h1);
		apb(1'b0, 12'h105, 32'h0, 1'b0);
		chk("misalign_err", {31'h0, er}, 32'h1);
		chk("misalign_rd", rd, 32'h0);
		$display("Test irq and refusals done");
		apb(1'b1, OFF_CTRL, 32'h1, 1'b0);
		mv = 1'b1;
		access_view <= 2'h0;
		wr(2, 3, 32'h0f0f_0f0f, 1'b0);
		wr(2, 1, 32'h0000_0001, 1'b0);
		wr(2, 2, 32'h0000_0020, 1'b0);
		access_view <= 2'h2;
		wr(2, 4, 32'hf0f0_f0f0, 1'b0);
		wr(0, 1, 32'h8000_0001, 1'b0);
		rdall("multi view");
		@(posedge pclk);
		spi_fault <= (128'h1 << 40) | 128'h1;
		@(posedge pclk);
		spi_fault <= '0;
		e_m[40] = 1'b1;
		g_m[40] = 1'b1;
		e_m[0] = 1'b1;
		g_m[0] = 1'b1;
		repeat (3) @(posedge pclk);
		chk("irq_fault", {31'h0, irq}, 32'h1);
		rdall("fault");
		repeat (60)
		begin
			access_view <= 2'($urandom % 4);
			wr($urandom % 3, 1 + $urandom % 4, $urandom, 1'($urandom % 2));
		end
		rdall("random");
		wrap_up();
	end

endmodule
